// ===== frs_defines.vh
// Constants for the frequency reference source selector: register offsets,
// field positions, reset values and timing figures.
// Assumes a 10 MHz core clock and a byte-addressed 32-bit register bus.
`ifndef FRS_DEFINES_VH
`define FRS_DEFINES_VH

// Clock rate and timing figures
`define FRS_CLK_HZ          10000000
`define FRS_GATE_MS         100
`define FRS_GATE_CYC        ((`FRS_GATE_MS * `FRS_CLK_HZ) / 1000)
`define FRS_FLASH_MS        250
`define FRS_FLASH_CYC       ((`FRS_FLASH_MS * `FRS_CLK_HZ) / 1000)

// Register byte offsets
`define FRS_OFS_SRC         6'h00
`define FRS_OFS_A2CFG       6'h04
`define FRS_OFS_DINFN       6'h08
`define FRS_OFS_PCFG        6'h0c
`define FRS_OFS_PFS         6'h10
`define FRS_OFS_MAXF        6'h14
`define FRS_OFS_MINF        6'h18
`define FRS_OFS_PRE0        6'h1c
`define FRS_OFS_PRE3        6'h28
`define FRS_OFS_REF         6'h2c
`define FRS_OFS_STATE       6'h30
`define FRS_OFS_ISTAT       6'h34
`define FRS_OFS_IMASK       6'h38

// Source selector encodings and reset value
`define FRS_SRC_KEYPAD      3'h0
`define FRS_SRC_ANALOG      3'h1
`define FRS_SRC_SERIAL      3'h2
`define FRS_SRC_OPTION      3'h3
`define FRS_SRC_PULSE       3'h4
`define FRS_SRC_RST         3'h1

// Second analog input codes and field positions in the A2 config word
`define FRS_A2LVL_LSB       0
`define FRS_A2FN_LSB        8
`define FRS_A2LVL_4_20      2'h2
`define FRS_A2LVL_0_20      2'h3
`define FRS_A2FN_BIAS       5'h00
`define FRS_A2FN_AUX        5'h02
`define FRS_A2CFG_RST       32'h0000_0000

// Digital input function code for multi-step speed 1
`define FRS_DINFN_MS1       8'h03
`define FRS_DINFN_RST       8'h03

// Pulse input defaults
`define FRS_PFN_FREF        4'h0
`define FRS_PFS_RST         16'h05a0
`define FRS_MAXF_RST        16'h1770
`define FRS_MINF_RST        16'h0096

// Analog converter full scale and 4 mA offset (20 % of full scale)
`define FRS_ADC_FS          16'h0fff
`define FRS_ADC_4MA         16'h0333

// Interrupt status bits
`define FRS_IRQ_PERR        0
`define FRS_IRQ_ZREF        1
`define FRS_IRQ_MODE        2
`define FRS_IRQ_W           3

`endif

// ===== frs_scale.v
// Linear scaler: clamps an input to its full scale and maps it onto 0..max.
// Assumes a purely combinational use; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none

module frs_scale #(
  parameter XW = 16
) (
  // Operands
  input  wire [XW-1:0] x,
  input  wire [XW-1:0] full_scale,
  input  wire [15:0]   max_val,
  // Result
  output wire [15:0]   y
);

  wire [XW-1:0]    x_clamp;
  wire [XW+15:0]   prod;
  wire [XW+15:0]   quot;

  // Clamp so an over-range input still yields at most max_val
  assign x_clamp = (x > full_scale) ? full_scale : x;
  assign prod    = x_clamp * max_val;
  // A zero full scale would divide by zero; treat it as no reference
  assign quot    = (full_scale == {XW{1'b0}}) ? {(XW+16){1'b0}} : prod / full_scale;
  assign y       = quot[15:0];

endmodule // frs_scale

`default_nettype wire

// ===== frs_pulse_meter.v
// Pulse train frequency meter: counts rising edges in a fixed gate window.
// Assumes the pulse pin is already synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none

module frs_pulse_meter #(
  parameter GATE_CYC = 1000000,
  parameter CLK_HZ   = 10000000
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Pulse input
  input  wire        pulse_in,
  // Measured frequency in Hz
  output reg  [15:0] freq_hz_r
);

  reg  [31:0] gate_cnt_r;
  reg  [15:0] edge_cnt_r;
  reg         pulse_d_r;
  wire        rise;
  wire        gate_end;
  wire [47:0] hz_full;

  assign rise     = pulse_in & ~pulse_d_r;
  assign gate_end = (gate_cnt_r == GATE_CYC - 1);
  // Edges per window times windows per second
  assign hz_full  = ({32'h0, edge_cnt_r} * CLK_HZ) / GATE_CYC;

  // Gate counter, edge counter and result latch
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      gate_cnt_r <= 32'h0;
      edge_cnt_r <= 16'h0;
      pulse_d_r  <= 1'b0;
      freq_hz_r  <= 16'h0;
    end
    else
    begin
      pulse_d_r <= pulse_in;
      if (gate_end)
      begin
        gate_cnt_r <= 32'h0;
        edge_cnt_r <= {15'h0, rise};
        freq_hz_r  <= (hz_full > 48'h0000_0000_ffff) ? 16'hffff : hz_full[15:0];
      end
      else
      begin
        gate_cnt_r <= gate_cnt_r + 32'h1;
        // Saturate rather than wrap on an out-of-spec input
        if (rise && edge_cnt_r != 16'hffff)
          edge_cnt_r <= edge_cnt_r + 16'h1;
      end
    end
  end

endmodule // frs_pulse_meter

`default_nettype wire

// ===== frs_ref_select.v
// Frequency reference source selector with Avalon-MM register slave.
// Assumes all inputs synchronous to core_clk and analog codes 12 bits wide.
`timescale 1ns/1ns
`default_nettype none
`include "frs_defines.vh"

module frs_ref_select #(
  parameter GATE_CYC  = `FRS_GATE_CYC,
  parameter FLASH_CYC = `FRS_FLASH_CYC
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Avalon-MM slave
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Operator keypad
  input  wire        local_remote_key,
  input  wire [15:0] keypad_ref,
  // Control terminals
  input  wire [11:0] main_analog_input,
  input  wire [11:0] auxiliary_analog_input,
  input  wire        digital_input_five,
  input  wire        speed_step_two,
  input  wire        pulse_train_input_pin,
  input  wire        run_cmd,
  // Serial link and option board connector
  input  wire [15:0] serial_ref,
  input  wire        option_present,
  input  wire [15:0] option_ref,
  // Outputs
  output reg  [15:0] freq_ref_r,
  output wire        run_enable,
  output reg         run_led_r,
  output reg         stop_led_r,
  output wire        option_missing_program_error,
  output wire        irq
);

  // Software registers
  reg  [2:0]  src_sel_r;
  reg  [1:0]  a2_level_r;
  reg  [4:0]  a2_func_r;
  reg  [7:0]  din_func_r;
  reg  [3:0]  pulse_func_r;
  reg  [15:0] pulse_full_scale_r;
  reg  [15:0] max_freq_r;
  reg  [15:0] min_freq_r;
  reg  [15:0] preset_r [0:3];
  reg  [`FRS_IRQ_W-1:0] irq_stat_r;
  reg  [`FRS_IRQ_W-1:0] irq_mask_r;
  // Block state
  reg         local_r;
  reg         key_d_r;
  reg         ack_r;
  reg         perr_d_r;
  reg         zref_d_r;
  reg  [31:0] flash_cnt_r;
  reg         flash_r;

  wire        access;
  wire        wr_go;
  wire [`FRS_IRQ_W-1:0] irq_set;
  wire        key_press;
  wire        ms1_closed;
  wire [15:0] main_ref;
  wire [15:0] aux_ref;
  wire [15:0] aux_x;
  wire [15:0] aux_fs;
  wire [15:0] pulse_hz;
  wire [15:0] pulse_ref;
  wire        zero_ref;
  wire [2:0]  eff_src;
  reg  [15:0] ref_nxt;
  reg  [16:0] sum;
  reg  [31:0] rd_nxt;

  // Bus handshake: one wait cycle, then the access completes
  assign access          = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack_r;
  assign wr_go           = avs_write & ack_r;

  always @(posedge core_clk)
  begin
    if (!rstn)
      ack_r <= 1'b0;
    else
      ack_r <= access & ~ack_r;
  end

  // Local/remote key edge toggles the mode
  assign key_press = local_remote_key & ~key_d_r;

  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      key_d_r <= 1'b0;
      local_r <= 1'b0;
    end
    else
    begin
      key_d_r <= local_remote_key;
      if (key_press)
        local_r <= ~local_r;
    end
  end

  assign eff_src = local_r ? `FRS_SRC_KEYPAD : src_sel_r;

  assign option_missing_program_error = (src_sel_r == `FRS_SRC_OPTION) & ~option_present;
  assign run_enable = run_cmd & ~option_missing_program_error;

  assign ms1_closed = digital_input_five & (din_func_r == `FRS_DINFN_MS1);

  frs_scale #(
    .XW (16)
  ) u_main_scale (
    .x          ({4'h0, main_analog_input}),
    .full_scale (`FRS_ADC_FS),
    .max_val    (max_freq_r),
    .y          (main_ref)
  );

  // Live zero removed for 4-20 mA
  assign aux_x  = (a2_level_r == `FRS_A2LVL_4_20) ?
                  (({4'h0, auxiliary_analog_input} > `FRS_ADC_4MA) ?
                   ({4'h0, auxiliary_analog_input} - `FRS_ADC_4MA) : 16'h0) :
                  {4'h0, auxiliary_analog_input};
  assign aux_fs = (a2_level_r == `FRS_A2LVL_4_20) ? (`FRS_ADC_FS - `FRS_ADC_4MA) : `FRS_ADC_FS;

  frs_scale #(
    .XW (16)
  ) u_aux_scale (
    .x          (aux_x),
    .full_scale (aux_fs),
    .max_val    (max_freq_r),
    .y          (aux_ref)
  );

  // Pulse train measurement
  frs_pulse_meter #(
    .GATE_CYC (GATE_CYC),
    .CLK_HZ   (`FRS_CLK_HZ)
  ) u_pulse (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .pulse_in  (pulse_train_input_pin),
    .freq_hz_r (pulse_hz)
  );

  frs_scale #(
    .XW (16)
  ) u_pulse_scale (
    .x          (pulse_hz),
    .full_scale (pulse_full_scale_r),
    .max_val    (max_freq_r),
    .y          (pulse_ref)
  );

  // Source multiplexer; unused codes give no reference
  always @*
  begin
    sum     = {1'b0, main_ref} + {1'b0, aux_ref};
    ref_nxt = 16'h0;
    case (eff_src)
      `FRS_SRC_KEYPAD:
        ref_nxt = ({speed_step_two, ms1_closed} == 2'b00) ? keypad_ref :
                  preset_r[{speed_step_two, ms1_closed}];
      `FRS_SRC_ANALOG:
        if (a2_func_r == `FRS_A2FN_AUX)
          ref_nxt = ms1_closed ? aux_ref : main_ref;
        else if (a2_func_r == `FRS_A2FN_BIAS)
          // Bias may not push past maximum frequency
          ref_nxt = (sum > {1'b0, max_freq_r}) ? max_freq_r : sum[15:0];
        else
          ref_nxt = main_ref;
      `FRS_SRC_SERIAL:
        ref_nxt = serial_ref;
      `FRS_SRC_OPTION:
        ref_nxt = option_present ? option_ref : 16'h0;
      `FRS_SRC_PULSE:
        ref_nxt = (pulse_func_r == `FRS_PFN_FREF) ? pulse_ref : 16'h0;
      default:
        ref_nxt = 16'h0;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!rstn)
      freq_ref_r <= 16'h0;
    else
      freq_ref_r <= ref_nxt;
  end

  // Zero or below minimum while running
  assign zero_ref = run_enable & ((freq_ref_r == 16'h0) | (freq_ref_r < min_freq_r));

  // Flash timer runs only while needed so the stop lamp starts lit
  always @(posedge core_clk)
  begin
    if (!rstn || !zero_ref)
    begin
      flash_cnt_r <= 32'h0;
      flash_r     <= 1'b1;
    end
    else if (flash_cnt_r == FLASH_CYC - 1)
    begin
      flash_cnt_r <= 32'h0;
      flash_r     <= ~flash_r;
    end
    else
      flash_cnt_r <= flash_cnt_r + 32'h1;
  end

  // Run lamp follows run enable; stop lamp flashes on zero reference, else lit while stopped
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      run_led_r  <= 1'b0;
      stop_led_r <= 1'b1;
    end
    else
    begin
      run_led_r  <= run_enable;
      stop_led_r <= zero_ref ? flash_r : ~run_enable;
    end
  end

  // Interrupt events: rising error, rising zero-reference, mode change
  assign irq_set[`FRS_IRQ_PERR] = option_missing_program_error & ~perr_d_r;
  assign irq_set[`FRS_IRQ_ZREF] = zero_ref & ~zref_d_r;
  assign irq_set[`FRS_IRQ_MODE] = key_press;
  assign irq = |(irq_stat_r & irq_mask_r);

  // Register writes; sticky status with set winning over clear
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      src_sel_r          <= `FRS_SRC_RST;
      a2_level_r         <= 2'h0;
      a2_func_r          <= `FRS_A2FN_BIAS;
      din_func_r         <= `FRS_DINFN_RST;
      pulse_func_r       <= `FRS_PFN_FREF;
      pulse_full_scale_r <= `FRS_PFS_RST;
      max_freq_r         <= `FRS_MAXF_RST;
      min_freq_r         <= `FRS_MINF_RST;
      preset_r[0]        <= 16'h0;
      preset_r[1]        <= 16'h0;
      preset_r[2]        <= 16'h0;
      preset_r[3]        <= 16'h0;
      irq_stat_r         <= {`FRS_IRQ_W{1'b0}};
      irq_mask_r         <= {`FRS_IRQ_W{1'b0}};
      perr_d_r           <= 1'b0;
      zref_d_r           <= 1'b0;
    end
    else
    begin
      perr_d_r   <= option_missing_program_error;
      zref_d_r   <= zero_ref;
      irq_stat_r <= (irq_stat_r &
                     ~((wr_go && avs_address == `FRS_OFS_ISTAT) ?
                       avs_writedata[`FRS_IRQ_W-1:0] : {`FRS_IRQ_W{1'b0}})) | irq_set;
      if (wr_go)
      begin
        case (avs_address)
          // Selector takes 0..4; other codes ignored
          `FRS_OFS_SRC:
            if (avs_writedata[2:0] <= `FRS_SRC_PULSE)
              src_sel_r <= avs_writedata[2:0];
          `FRS_OFS_A2CFG:
          begin
            a2_level_r <= avs_writedata[`FRS_A2LVL_LSB +: 2];
            a2_func_r  <= avs_writedata[`FRS_A2FN_LSB +: 5];
          end
          `FRS_OFS_DINFN: din_func_r         <= avs_writedata[7:0];
          `FRS_OFS_PCFG:  pulse_func_r       <= avs_writedata[3:0];
          `FRS_OFS_PFS:   pulse_full_scale_r <= avs_writedata[15:0];
          `FRS_OFS_MAXF:  max_freq_r         <= avs_writedata[15:0];
          `FRS_OFS_MINF:  min_freq_r         <= avs_writedata[15:0];
          `FRS_OFS_IMASK: irq_mask_r         <= avs_writedata[`FRS_IRQ_W-1:0];
          default:
            if (avs_address >= `FRS_OFS_PRE0 && avs_address <= `FRS_OFS_PRE3)
              preset_r[avs_address[3:2] - 2'h3] <= avs_writedata[15:0];
        endcase
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always @*
  begin
    rd_nxt = 32'h0;
    case (avs_address)
      `FRS_OFS_SRC:   rd_nxt = {29'h0, src_sel_r};
      `FRS_OFS_A2CFG: rd_nxt = {19'h0, a2_func_r, 6'h0, a2_level_r};
      `FRS_OFS_DINFN: rd_nxt = {24'h0, din_func_r};
      `FRS_OFS_PCFG:  rd_nxt = {28'h0, pulse_func_r};
      `FRS_OFS_PFS:   rd_nxt = {16'h0, pulse_full_scale_r};
      `FRS_OFS_MAXF:  rd_nxt = {16'h0, max_freq_r};
      `FRS_OFS_MINF:  rd_nxt = {16'h0, min_freq_r};
      `FRS_OFS_REF:   rd_nxt = {pulse_hz, freq_ref_r};
      `FRS_OFS_STATE: rd_nxt = {24'h0, option_missing_program_error, zero_ref,
                                run_enable, local_r, 1'b0, eff_src};
      `FRS_OFS_ISTAT: rd_nxt = {29'h0, irq_stat_r};
      `FRS_OFS_IMASK: rd_nxt = {29'h0, irq_mask_r};
      default:
        if (avs_address >= `FRS_OFS_PRE0 && avs_address <= `FRS_OFS_PRE3)
          rd_nxt = {16'h0, preset_r[avs_address[3:2] - 2'h3]};
    endcase
  end

  // Read data captured in the wait cycle, stands when waitrequest drops
  always @(posedge core_clk)
  begin
    if (!rstn)
      avs_readdata <= 32'h0;
    else if (avs_read && !ack_r)
      avs_readdata <= rd_nxt;
  end

endmodule // frs_ref_select

`default_nettype wire

// ===== frs_ref_checker.sv
// Checker for the reference source selector ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module frs_ref_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // Register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Run path
  input wire logic        option_present,
  input wire logic        run_cmd,
  input wire logic        run_enable,
  input wire logic        run_led_r,
  input wire logic        stop_led_r,
  input wire logic        option_missing_program_error,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // Run gating and error flag
  AST_RUN_EN: assert property (run_enable == (run_cmd && !option_missing_program_error))
    else $error("run enable not gated by error");
  AST_RUN_REFUSED: assert property (option_missing_program_error |-> !run_enable)
    else $error("run accepted with error");
  AST_PERR_BOARD: assert property (option_present |-> !option_missing_program_error)
    else $error("error with board fitted");
  AST_PERR_DARK: assert property (option_missing_program_error |=> !run_led_r)
    else $error("run lamp lit with error");
  // Run lamp follows run enable one cycle later, stop lamp lit the cycle after a stop; guarded at reset release
  AST_RUN_LED: assert property ($past(rstn) |-> run_led_r == $past(run_enable))
    else $error("run lamp wrong");
  AST_STOP_LED: assert property (!run_enable |=> stop_led_r)
    else $error("stop lamp dark while stopped");
  // Bus answers after exactly one wait cycle
  AST_WAIT_ONE: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state count wrong");
  AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");

  // Main scenarios
  COV_PERR: cover property ($rose(option_missing_program_error));
  COV_IRQ: cover property ($rose(irq));
  COV_FLASH: cover property (run_led_r && $fell(stop_led_r));
endmodule // frs_ref_checker

bind frs_ref_select frs_ref_checker u_chk (
  .core_clk(core_clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .option_present(option_present), .run_cmd(run_cmd), .run_enable(run_enable),
  .run_led_r(run_led_r), .stop_led_r(stop_led_r), .irq(irq),
  .option_missing_program_error(option_missing_program_error)
);

`default_nettype wire

// ===== frs_far_model.sv
// Far side model: serial master, option board and pulse source.
// Assumes the bench steers pulse enable and board presence.
`timescale 1ns/1ns
`default_nettype none

module frs_far_model #(
  parameter logic [15:0] HALF = 16'h03e8
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Controls
  input  wire logic        pulse_en,
  input  wire logic        fitted,
  // Far side
  output var  logic        pulse_out,
  output wire logic        option_present,
  output wire logic [15:0] option_ref,
  output wire logic [15:0] serial_ref
);
  logic [15:0] cnt_r;

  // pulse train source
  // Square wave of period 2*HALF; stands low while disabled
  always @(posedge core_clk)
  begin
    if (!rstn || !pulse_en)
    begin
      cnt_r     <= 16'h0000;
      pulse_out <= 1'b0;
    end
    else if (cnt_r == HALF - 16'h0001)
    begin
      cnt_r     <= 16'h0000;
      pulse_out <= ~pulse_out;
    end
    else
      cnt_r <= cnt_r + 16'h0001;
  end

  // link references
  // A pulled board shows the inverse, so stale data cannot pass
  assign option_present = fitted;
  assign option_ref     = fitted ? 16'h0c35 : 16'hf3ca;
  assign serial_ref     = 16'h07d0;
endmodule // frs_far_model

`default_nettype wire

// ===== tb_top.sv
// Bench for the reference selector, driven over its register bus.
// Assumes the far side model supplies link references and pulses.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic        rd_s = 1'b0;
  logic        wr_s = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        lrk = 1'b0;
  logic [15:0] kref = 16'h04d2;
  logic [11:0] ain1 = 12'h9c4;
  logic [11:0] ain2 = 12'h3e8;
  logic        din5 = 1'b0;
  logic        sst = 1'b0;
  logic        run = 1'b0;
  logic        pen = 1'b0;
  logic        fit = 1'b1;
  logic        pls, opp, s;
  wire  [31:0] rdat;
  wire  [15:0] oref, sref, fref;
  wire         wreq, run_en, rled, sled, perr, irq;
  logic [31:0] q;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          t;

  frs_ref_select #(.GATE_CYC(10000), .FLASH_CYC(4)) dut (
    .core_clk(core_clk), .rstn(rstn), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .local_remote_key(lrk), .keypad_ref(kref),
    .main_analog_input(ain1), .auxiliary_analog_input(ain2),
    .digital_input_five(din5), .speed_step_two(sst),
    .pulse_train_input_pin(pls), .run_cmd(run), .serial_ref(sref),
    .option_present(opp), .option_ref(oref), .freq_ref_r(fref),
    .run_enable(run_en), .run_led_r(rled), .stop_led_r(sled),
    .option_missing_program_error(perr), .irq(irq));

  frs_far_model far (.core_clk(core_clk), .rstn(rstn), .pulse_en(pen), .fitted(fit),
    .pulse_out(pls), .option_present(opp), .option_ref(oref), .serial_ref(sref));

  // 10 MHz clock
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic close_out;
    $display("compares %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // One bus cycle; held until waitrequest is sampled low at a rising edge, bounded
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    adr  <= a;
    wd   <= d;
    wr_s <= w;
    rd_s <= ~w;
    i = 0;
    do
    begin
      @(posedge core_clk);
      i++;
    end
    while (wreq !== 1'b0 && i < 20);
    if (wreq !== 1'b0)
    begin
      n_errors++;
      close_out;
    end
    // Completing edge: read data taken here, request released right after
    q = rdat;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask

  // Write, then let the register and the registered reference settle
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    tk(2);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // Outputs are read at rising edges, where they hold their settled values
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    rdc(6'h00, 32'h1);
    rdc(6'h04, 32'h0);
    rdc(6'h08, 32'h3);
    rdc(6'h10, 32'h5a0);
    rdc(6'h3c, 32'h0);
    wr(6'h00, 32'h5);
    rdc(6'h00, 32'h1);
    // Analog main/aux switch, unit gain via full scale max
    wr(6'h14, 32'hfff);
    wr(6'h04, 32'h200);
    chk(fref, 32'h9c4);
    din5 <= 1'b1;
    tk(3);
    chk(fref, 32'h3e8);
    wr(6'h04, 32'h202);
    ain2 <= 12'hfff;
    tk(3);
    chk(fref, 32'hfff);
    ain2 <= 12'h300;
    tk(3);
    chk(fref, 32'h0);
    wr(6'h04, 32'h003);
    ain2 <= 12'h1f4;
    tk(3);
    chk(fref, 32'hbb8);
    // Keypad and presets
    wr(6'h20, 32'h6f);
    wr(6'h28, 32'h14d);
    wr(6'h00, 32'h0);
    chk(fref, 32'h6f);
    sst <= 1'b1;
    tk(3);
    chk(fref, 32'h14d);
    din5 <= 1'b0;
    sst <= 1'b0;
    tk(3);
    chk(fref, 32'h4d2);
    wr(6'h00, 32'h2);
    chk(fref, 32'h7d0);
    // Option board, then pulled with run requested
    wr(6'h38, 32'h1);
    wr(6'h00, 32'h3);
    chk(fref, 32'hc35);
    fit <= 1'b0;
    run <= 1'b1;
    tk(3);
    chk({perr, run_en, rled, irq}, 32'h9);
    wr(6'h34, 32'h1);
    chk(irq, 32'h0);
    run <= 1'b0;
    fit <= 1'b1;
    // Pulse train: five edges per gate gives 5000 Hz
    wr(6'h14, 32'h2710);
    wr(6'h10, 32'h2710);
    wr(6'h00, 32'h4);
    pen <= 1'b1;
    tk(25000);
    chk(fref, 32'h1388);
    rdc(6'h2c, 32'h13881388);
    wr(6'h10, 32'hfa0);
    chk(fref, 32'h2710);
    pen <= 1'b0;
    // Local key: keypad wins, event masked then unmasked
    lrk <= 1'b1;
    tk(3);
    chk(fref, 32'h4d2);
    chk(irq, 32'h0);
    rdc(6'h34, 32'h4);
    wr(6'h38, 32'h4);
    chk(irq, 32'h1);
    wr(6'h34, 32'h4);
    chk(irq, 32'h0);
    lrk <= 1'b0;
    // Zero reference while running: stop lamp flashes
    kref <= 16'h0000;
    run <= 1'b1;
    tk(3);
    chk(rled, 32'h1);
    t = 0;
    s = sled;
    repeat (24)
    begin
      tk(1);
      if (sled !== s)
        t++;
      s = sled;
    end
    chk(t >= 3, 32'h1);
    rdc(6'h34, 32'h2);
    rdc(6'h30, 32'h70);
    close_out;
  end
endmodule // tb_top

`default_nettype wire
